// ==== adcbr_pkg.sv ====
// Package for the converter B input range register bank.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package adcbr_pkg;

    // ==========================================================
    // Register indices and byte addresses
    // ==========================================================
    localparam logic [7:0] IDX_LOWER = 8'h06;
    localparam logic [7:0] IDX_UPPER = 8'h07;
    localparam logic [7:0] ADR_LOWER = {IDX_LOWER[5:0], 2'b00};
    localparam logic [7:0] ADR_UPPER = {IDX_UPPER[5:0], 2'b00};

    // ==========================================================
    // Field layout
    // ==========================================================
    localparam int ADDR_FIELD_MSB = 15;
    localparam int ADDR_FIELD_LSB = 9;
    localparam int RSVD_BIT = 8;
    localparam int FIELD_W = 2;
    localparam int CH_PER_REG = 4;
    localparam int NUM_CH = 8;
    localparam int REG_W = 16;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [15:0] RANGE_REG_RST = 16'h00FF;
    localparam logic [1:0] RANGE_FIELD_RST = 2'h3;

    // ==========================================================
    // Range codes
    // ==========================================================
    localparam logic [1:0] CODE_10V_A = 2'h0;
    localparam logic [1:0] CODE_2P5V = 2'h1;
    localparam logic [1:0] CODE_5V = 2'h2;
    localparam logic [1:0] CODE_10V_B = 2'h3;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        RNG_10V,
        RNG_5V,
        RNG_2P5V
    } adcbr_range_t;

    typedef enum logic {
        CONV_IDLE,
        CONV_ACTIVE
    } adcbr_conv_state_t;

    typedef struct packed {
        logic [6:0] addr_field;
        logic rsvd;
        logic [3:0][1:0] fields;
    } adcbr_range_reg_t;

endpackage

// ==== adcbr_range_dec.sv ====
// Decoder from a 2-bit range field to a range selection.
// Assumes the caller registers the result.
`timescale 1ns/1ns

module adcbr_range_dec (
    input wire logic [1:0] i_code,
    output adcbr_pkg::adcbr_range_t o_range
);

    // ==========================================================
    // Decode
    // ==========================================================
    always_comb begin
        case (i_code)
            adcbr_pkg::CODE_10V_A: begin
                o_range = adcbr_pkg::RNG_10V;
            end
            adcbr_pkg::CODE_2P5V: begin
                o_range = adcbr_pkg::RNG_2P5V;
            end
            adcbr_pkg::CODE_5V: begin
                o_range = adcbr_pkg::RNG_5V;
            end
            adcbr_pkg::CODE_10V_B: begin
                o_range = adcbr_pkg::RNG_10V;
            end
            default: begin
                o_range = adcbr_pkg::RNG_10V;
            end
        endcase
    end

endmodule

// ==== adcbr_regs.sv ====
// Converter B input range registers behind a classic Wishbone slave.
// Assumes one clock, synchronous active-low reset, and a converter
// that pulses start and done around each conversion.
`timescale 1ns/1ns

module adcbr_regs #(
    parameter int AW = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [AW-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_conv_start,
    input wire logic i_conv_done,
    output logic o_conv_busy,
    output logic [adcbr_pkg::NUM_CH-1:0][1:0] o_conv_b_range,
    output adcbr_pkg::adcbr_range_t [adcbr_pkg::NUM_CH-1:0] o_conv_b_range_sel
);

    // ==========================================================
    // Declarations
    // ==========================================================
    adcbr_pkg::adcbr_range_reg_t lower_r;
    adcbr_pkg::adcbr_range_reg_t lower_nxt;
    adcbr_pkg::adcbr_range_reg_t upper_r;
    adcbr_pkg::adcbr_range_reg_t upper_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic req;
    logic hit_lower;
    logic hit_upper;

    adcbr_pkg::adcbr_conv_state_t state_r;
    adcbr_pkg::adcbr_conv_state_t state_nxt;
    logic busy_r;
    logic busy_nxt;
    logic [adcbr_pkg::NUM_CH-1:0][1:0] snap_code_r;
    logic [adcbr_pkg::NUM_CH-1:0][1:0] snap_code_nxt;
    adcbr_pkg::adcbr_range_t [adcbr_pkg::NUM_CH-1:0] snap_sel_r;
    adcbr_pkg::adcbr_range_t [adcbr_pkg::NUM_CH-1:0] snap_sel_nxt;

    logic [adcbr_pkg::NUM_CH-1:0][1:0] live_code;
    adcbr_pkg::adcbr_range_t [adcbr_pkg::NUM_CH-1:0] live_sel;

    logic [1:0] conv_b_input_zero_range;
    logic [1:0] conv_b_input_one_range;
    logic [1:0] conv_b_input_two_range;
    logic [1:0] conv_b_input_three_range;
    logic [1:0] conv_b_input_four_range;
    logic [1:0] conv_b_input_five_range;
    logic [1:0] conv_b_input_six_range;
    logic [1:0] conv_b_input_seven_range;

    // ==========================================================
    // Byte-lane merge
    // ==========================================================
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_val,
        input logic [31:0] wdat,
        input logic [3:0] sel
    );
        logic [15:0] res;
        res = old_val;
        if (sel[0]) begin
            res[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wdat[15:8];
        end
        return res;
    endfunction

    // ==========================================================
    // Field taps
    // ==========================================================
    assign conv_b_input_zero_range = lower_r.fields[0];
    assign conv_b_input_one_range = lower_r.fields[1];
    assign conv_b_input_two_range = lower_r.fields[2];
    assign conv_b_input_three_range = lower_r.fields[3];
    assign conv_b_input_four_range = upper_r.fields[0];
    assign conv_b_input_five_range = upper_r.fields[1];
    assign conv_b_input_six_range = upper_r.fields[2];
    assign conv_b_input_seven_range = upper_r.fields[3];

    assign live_code = {conv_b_input_seven_range, conv_b_input_six_range,
                        conv_b_input_five_range, conv_b_input_four_range,
                        conv_b_input_three_range, conv_b_input_two_range,
                        conv_b_input_one_range, conv_b_input_zero_range};

    // ==========================================================
    // Per-channel decoders
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < adcbr_pkg::NUM_CH; gi++) begin : g_dec
            adcbr_range_dec u_dec (
                .i_code(live_code[gi]),
                .o_range(live_sel[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Wishbone slave
    // ==========================================================
    assign req = i_wb_cyc & i_wb_stb & ~ack_r;
    assign hit_lower = (i_wb_adr == AW'(adcbr_pkg::ADR_LOWER));
    assign hit_upper = (i_wb_adr == AW'(adcbr_pkg::ADR_UPPER));

    always_comb begin
        lower_nxt = lower_r;
        upper_nxt = upper_r;
        ack_nxt = req;
        rdat_nxt = rdat_r;
        if (req && i_wb_we) begin
            if (hit_lower) begin
                lower_nxt = lane_merge(lower_r, i_wb_dat, i_wb_sel);
            end
            if (hit_upper) begin
                upper_nxt = lane_merge(upper_r, i_wb_dat, i_wb_sel);
            end
        end
        if (req && !i_wb_we) begin
            if (hit_lower) begin
                rdat_nxt = {16'h0000, lower_r};
            end else if (hit_upper) begin
                rdat_nxt = {16'h0000, upper_r};
            end else begin
                rdat_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            lower_r <= adcbr_pkg::RANGE_REG_RST;
            upper_r <= adcbr_pkg::RANGE_REG_RST;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            lower_r <= lower_nxt;
            upper_r <= upper_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    // ==========================================================
    // Conversion snapshot
    // ==========================================================
    always_comb begin
        state_nxt = state_r;
        snap_code_nxt = snap_code_r;
        snap_sel_nxt = snap_sel_r;
        case (state_r)
            adcbr_pkg::CONV_IDLE: begin
                if (i_conv_start) begin
                    state_nxt = adcbr_pkg::CONV_ACTIVE;
                    snap_code_nxt = live_code;
                    snap_sel_nxt = live_sel;
                end
            end
            adcbr_pkg::CONV_ACTIVE: begin
                if (i_conv_done) begin
                    state_nxt = adcbr_pkg::CONV_IDLE;
                end
            end
            default: begin
                state_nxt = adcbr_pkg::CONV_IDLE;
            end
        endcase
        busy_nxt = (state_nxt == adcbr_pkg::CONV_ACTIVE);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_r <= adcbr_pkg::CONV_IDLE;
            busy_r <= 1'b0;
            snap_code_r <= {adcbr_pkg::NUM_CH{adcbr_pkg::RANGE_FIELD_RST}};
            snap_sel_r <= {adcbr_pkg::NUM_CH{adcbr_pkg::RNG_10V}};
        end else begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
            snap_code_r <= snap_code_nxt;
            snap_sel_r <= snap_sel_nxt;
        end
    end

    assign o_conv_busy = busy_r;
    assign o_conv_b_range = snap_code_r;
    assign o_conv_b_range_sel = snap_sel_r;

    // ==========================================================
    // Assertions
    // ==========================================================
    logic take_start;
    assign take_start = i_conv_start && (state_r == adcbr_pkg::CONV_IDLE);

    a_reset_upper: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> upper_r == adcbr_pkg::RANGE_REG_RST)
        else $error("upper range register reset value wrong");

    a_reset_lower: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> (lower_r == adcbr_pkg::RANGE_REG_RST)
            && (lower_r.addr_field == 7'h00))
        else $error("lower range register reset value wrong");

    a_ack_single: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack not one cycle after request");

    a_write_upper: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (req && i_wb_we && hit_upper && i_wb_sel[1:0] == 2'b11)
            |=> upper_r == $past(i_wb_dat[15:0]))
        else $error("upper register write lost");

    a_read_lower: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (req && !i_wb_we && hit_lower) |=> o_wb_dat == {16'h0000, $past(lower_r)})
        else $error("lower register read data wrong");

    a_read_unmapped: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (req && !i_wb_we && !hit_lower && !hit_upper) |=> o_wb_dat == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_map_input_two: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start |=> o_conv_b_range[2] == $past(lower_r[5:4]))
        else $error("input 2 range not from bits 5:4");

    a_map_input_one: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start |=> o_conv_b_range[1] == $past(lower_r[3:2]))
        else $error("input 1 range not from bits 3:2");

    a_map_input_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start |=> o_conv_b_range[0] == $past(lower_r[1:0]))
        else $error("input 0 range not from bits 1:0");

    a_map_input_seven: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start |=> o_conv_b_range[7] == $past(upper_r[7:6]))
        else $error("input 7 range not from bits 7:6");

    a_map_input_six: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start |=> o_conv_b_range[6] == $past(upper_r[5:4]))
        else $error("input 6 range not from bits 5:4");

    a_map_input_five: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start |=> o_conv_b_range[5] == $past(upper_r[3:2]))
        else $error("input 5 range not from bits 3:2");

    a_map_input_four: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start |=> o_conv_b_range[4] == $past(upper_r[1:0]))
        else $error("input 4 range not from bits 1:0");

    a_decode_three: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (take_start && lower_r[7:6] == adcbr_pkg::CODE_2P5V)
            |=> o_conv_b_range_sel[3] == adcbr_pkg::RNG_2P5V)
        else $error("input 3 code 01 not decoded as 2.5 V");

    a_decode_ten: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (take_start && lower_r[1:0] == adcbr_pkg::CODE_10V_A)
            |=> o_conv_b_range_sel[0] == adcbr_pkg::RNG_10V)
        else $error("input 0 code 00 not decoded as 10 V");

    a_hold_in_conv: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (o_conv_busy && !i_conv_done) |=> $stable(o_conv_b_range) && $stable(o_conv_busy))
        else $error("range changed during conversion");

    a_busy_on_start: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start |=> o_conv_busy)
        else $error("start not taken");

    a_map_input_three: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start |=> o_conv_b_range[3] == $past(lower_r[7:6]))
        else $error("input 3 range not from bits 7:6");

    a_write_lower: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (req && i_wb_we && hit_lower && i_wb_sel[1:0] == 2'b11)
            |=> lower_r == $past(i_wb_dat[15:0]))
        else $error("lower register write lost");

    a_write_low_lane: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (req && i_wb_we && hit_lower && i_wb_sel[1:0] == 2'b01)
            |=> (lower_r[15:8] == $past(lower_r[15:8]))
            && (lower_r[7:0] == $past(i_wb_dat[7:0])))
        else $error("lower register lane merge wrong");

    a_read_upper: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (req && !i_wb_we && hit_upper) |=> o_wb_dat == {16'h0000, $past(upper_r)})
        else $error("upper register read data wrong");

    a_decode_five: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (take_start && upper_r[3:2] == adcbr_pkg::CODE_5V)
            |=> o_conv_b_range_sel[5] == adcbr_pkg::RNG_5V)
        else $error("input 5 code 10 not decoded as 5 V");

    a_decode_ten_upper: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (take_start && upper_r[7:6] == adcbr_pkg::CODE_10V_B)
            |=> o_conv_b_range_sel[7] == adcbr_pkg::RNG_10V)
        else $error("input 7 code 11 not decoded as 10 V");

    a_busy_after_done: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (o_conv_busy && i_conv_done) |=> !o_conv_busy)
        else $error("busy not cleared after done");

    a_range_idle_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!o_conv_busy && !take_start) |=> $stable(o_conv_b_range))
        else $error("range changed without a start");

    a_ack_needs_req: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_wb_ack |-> $past(req))
        else $error("ack without a request");

    c_write_upper: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        req && i_wb_we && hit_upper);

    c_read_lower: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        req && !i_wb_we && hit_lower);

    c_write_in_conv: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_conv_busy && req && i_wb_we && (hit_lower || hit_upper));

    c_start_done: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        take_start ##[1:20] (o_conv_busy && i_conv_done));

endmodule

// ==== adcbr_conv_model.sv ====
// Converter model that pulses start and, after a set latency, done.
// Assumes the bench commands each conversion by a one-cycle go pulse.
`timescale 1ns/1ns

module adcbr_conv_model (
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic [3:0] i_lat,
    output logic o_start,
    output logic o_done
);
    // ==========================================
    // Start and done pulses
    // ==========================================
    logic [3:0] cnt_r;

    initial begin
        o_start = 1'b0;
        o_done = 1'b0;
        cnt_r = 4'h0;
    end

    always @(posedge i_mclk) begin
        o_start <= 1'b0;
        o_done <= 1'b0;
        if (i_go) begin
            o_start <= 1'b1;
            cnt_r <= i_lat;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
            o_done <= (cnt_r == 4'h1);
        end
    end
endmodule

// ==== adc_b_input_range_registers_test.sv ====
// Self-checking bench for the converter B range registers.
// Assumes the converter model file is compiled first.
`timescale 1ns/1ns

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end

module adc_b_input_range_registers_test;
    // ==========================================
    // Signals
    // ==========================================
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, lat = 4'h1;
    logic [31:0] dat = 32'h0, o_wb_dat;
    logic o_wb_ack, start, done, o_conv_busy, busy_d = 1'b0;
    logic [7:0][1:0] o_conv_b_range;
    adcbr_pkg::adcbr_range_t [7:0] o_conv_b_range_sel, es;
    logic [15:0] lo_e = 16'h00FF, up_e = 16'h00FF, v, mv;
    logic [16:0] rd_q[$];
    logic [15:0] rng_q[$];
    int n_mismatch = 0, num_checks = 0;

    initial forever #2 i_mclk = ~i_mclk;

    adcbr_regs adcbr_regs_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_conv_start(start),
        .i_conv_done(done), .o_conv_busy(o_conv_busy), .o_conv_b_range(o_conv_b_range),
        .o_conv_b_range_sel(o_conv_b_range_sel));
    adcbr_conv_model adcbr_conv_model_inst (.i_mclk(i_mclk), .i_go(go), .i_lat(lat),
        .o_start(start), .o_done(done));

    // ==========================================
    // Monitor
    // ==========================================
    always @(posedge i_mclk) begin
        busy_d <= o_conv_busy;
        if (o_wb_ack === 1'b1 && rd_q.size() > 0) begin
            mv = rd_q[0][15:0];
            if (rd_q.pop_front() > 17'hFFFF) `CHK(o_wb_dat, {16'h0, mv})
        end
        if (o_conv_busy === 1'b1 && busy_d === 1'b0 && rng_q.size() > 0) begin
            mv = rng_q.pop_front();
            for (int k = 0; k < 8; k++) begin
                es[k] = (mv[2*k+:2] == 2'h1) ? adcbr_pkg::RNG_2P5V :
                    (mv[2*k+:2] == 2'h2) ? adcbr_pkg::RNG_5V : adcbr_pkg::RNG_10V;
            end
            `CHK(o_conv_b_range, mv)
            `CHK(o_conv_b_range_sel, es)
        end
    end

    // ==========================================
    // Tasks
    // ==========================================
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
            input logic [3:0] s);
        int n;
        logic [15:0] m;
        m = {{8{s[1]}}, {8{s[0]}}};
        rd_q.push_back({~w, (a == adcbr_pkg::ADR_LOWER) ? lo_e :
            (a == adcbr_pkg::ADR_UPPER) ? up_e : 16'h0});
        if (w && a == adcbr_pkg::ADR_LOWER) lo_e = (lo_e & ~m) | (d & m);
        if (w && a == adcbr_pkg::ADR_UPPER) up_e = (up_e & ~m) | (d & m);
        n = 0;
        @(posedge i_mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= {16'($urandom), d};
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic conv(input logic note, input logic [3:0] l);
        if (note) rng_q.push_back({up_e[7:0], lo_e[7:0]});
        @(posedge i_mclk);
        go <= 1'b1;
        lat <= l;
        @(posedge i_mclk);
        go <= 1'b0;
    endtask

    task automatic idle();
        int n;
        n = 0;
        repeat (3) @(posedge i_mclk);
        while (o_conv_busy !== 1'b0 && n < 40) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 40) n_mismatch++;
    endtask

    task automatic results();
        `CHK(rd_q.size() + rng_q.size(), 0)
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Watchdog and main sequence
    // ==========================================
    initial begin
        #40000;
        n_mismatch++;
        results();
    end

    initial begin
        void'($urandom(68));
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        wb(1'b0, adcbr_pkg::ADR_LOWER, 16'h0, 4'h3);
        wb(1'b0, adcbr_pkg::ADR_UPPER, 16'h0, 4'h3);
        wb(1'b0, 8'h20, 16'h0, 4'h3);
        conv(1'b1, 4'h2);
        idle();
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 4; k++) begin
                v[2*k+:2] = 2'(k + i);
                v[8+2*k+:2] = 2'(k + 3 * i + 1);
            end
            wb(1'b1, adcbr_pkg::ADR_LOWER, {8'($urandom), v[7:0]}, 4'h3);
            wb(1'b1, adcbr_pkg::ADR_UPPER, {8'($urandom), v[15:8]}, 4'h3);
            wb(1'b0, adcbr_pkg::ADR_LOWER, 16'h0, 4'h3);
            wb(1'b0, adcbr_pkg::ADR_UPPER, 16'h0, 4'h3);
            conv(1'b1, 4'(1 + $urandom % 8));
            idle();
        end
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        lo_e = 16'h00FF;
        up_e = 16'h00FF;
        wb(1'b0, adcbr_pkg::ADR_LOWER, 16'h0, 4'h3);
        wb(1'b0, adcbr_pkg::ADR_UPPER, 16'h0, 4'h3);
        wb(1'b1, adcbr_pkg::ADR_LOWER, 16'($urandom), 4'h1);
        wb(1'b1, adcbr_pkg::ADR_UPPER, 16'($urandom), 4'h2);
        wb(1'b1, 8'h20, 16'($urandom), 4'h3);
        wb(1'b0, adcbr_pkg::ADR_LOWER, 16'h0, 4'h3);
        wb(1'b0, adcbr_pkg::ADR_UPPER, 16'h0, 4'h3);
        wb(1'b0, 8'h20, 16'h0, 4'h3);
        conv(1'b1, 4'hF);
        wb(1'b1, adcbr_pkg::ADR_LOWER, 16'h0E4, 4'h3);
        conv(1'b0, 4'h2);
        idle();
        conv(1'b1, 4'h1);
        idle();
        results();
    end
endmodule
